// ---- hdl/tpi_pkg.sv ----
// types shared by the pointer interpreter
package tpi_pkg;
  typedef enum logic [1:0] {
    ST_NORM = 2'h0,
    ST_AIS  = 2'h1,
    ST_LOP  = 2'h2
  } tpi_state_t;
  typedef enum logic [2:0] {
    TT_VT15 = 3'h0,
    TT_VT2  = 3'h1,
    TT_VT3  = 3'h2,
    TT_VT6  = 3'h3,
    TT_TU3  = 3'h4
  } tpi_trib_t;
endpackage

// ---- hdl/tpi_pointer_interp.sv ----
// time-sliced tributary pointer interpreter with payload fifo bank and axi4-lite registers
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "tpi_regs.svh"
module tpi_pointer_interp #(
  parameter int NTRIB  = 28,
  parameter int FDEPTH = 16,
  parameter int AW     = $clog2(FDEPTH)
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             awvalid,
  output logic                  awready,
  input  wire logic [7:0]       awaddr,
  input  wire logic             wvalid,
  output logic                  wready,
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       wstrb,
  output logic                  bvalid,
  input  wire logic             bready,
  output logic [1:0]            bresp,
  input  wire logic             arvalid,
  output logic                  arready,
  input  wire logic [7:0]       araddr,
  output logic                  rvalid,
  input  wire logic             rready,
  output logic [31:0]           rdata,
  output logic [1:0]            rresp,
  output logic                  slotFirst,
  input  wire logic [4:0]       inTrib,
  input  wire logic             inV1,
  input  wire logic             inV2,
  input  wire logic             inPay,
  input  wire logic [7:0]       inByte,
  input  wire logic [9:0]       inPos,
  input  wire logic [4:0]       rdTrib,
  input  wire logic             rdReq,
  output logic                  rdValid,
  output logic [7:0]            rdData,
  output logic                  rdMark,
  output logic [AW-1:0]         rdFill,
  output logic [NTRIB-1:0]      lopFlag,
  output logic [NTRIB-1:0]      aisFlag
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic maj5(input logic [4:0] v);
    maj5 = (3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]) + 3'(v[4])) >= 3'h3;
  endfunction
  function automatic logic near4(input logic [3:0] a, input logic [3:0] b);
    logic [3:0] x;
    x = a ^ b;
    near4 = (3'(x[0]) + 3'(x[1]) + 3'(x[2]) + 3'(x[3])) <= 3'h1;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // slot sequencer: phase 0 sample, 1 interpret and write, 2 read
  logic [1:0] phase;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase     <= 2'h0;
      slotFirst <= 1'b1;
    end else begin
      phase     <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      slotFirst <= (phase == 2'h2);
    end
  end
  logic [4:0] capTrib;
  logic       capV1;
  logic       capV2;
  logic       capPay;
  logic [7:0] capByte;
  logic [9:0] capPos;
  logic [4:0] capRdTrib;
  logic       capRdReq;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capTrib   <= 5'h00;
      capV1     <= 1'b0;
      capV2     <= 1'b0;
      capPay    <= 1'b0;
      capByte   <= 8'h00;
      capPos    <= 10'h000;
      capRdTrib <= 5'h00;
      capRdReq  <= 1'b0;
    end else if (phase == 2'h0) begin
      capTrib   <= inTrib;
      capV1     <= inV1 && (32'(inTrib) < NTRIB);
      capV2     <= inV2 && (32'(inTrib) < NTRIB);
      capPay    <= inPay && (32'(inTrib) < NTRIB);
      capByte   <= inByte;
      capPos    <= inPos;
      capRdTrib <= rdTrib;
      capRdReq  <= rdReq && (32'(rdTrib) < NTRIB);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // configuration
  logic      jspOff;
  logic      aisOne;
  tpi_pkg::tpi_trib_t tribType;
  // per tributary state vector
  tpi_pkg::tpi_state_t stArr [NTRIB];
  logic [9:0] actArr  [NTRIB];
  logic [9:0] newOff  [NTRIB];
  logic [7:0] b1Arr   [NTRIB];
  logic [2:0] invCnt  [NTRIB];
  logic [2:0] ndfCnt  [NTRIB];
  logic [1:0] aisCnt  [NTRIB];
  logic [1:0] newCnt  [NTRIB];
  logic [2:0] since   [NTRIB];
  logic [AW-1:0] wPtr [NTRIB];
  logic [AW-1:0] rPtr [NTRIB];
  ////////////////////////////////////////////////////////////////////////////
  // pointer classification, valid while phase 1 holds a second pointer byte
  logic [9:0] maxOff;
  logic [1:0] ssWant;
  always_comb begin
    case (tribType)
      tpi_pkg::TT_VT15: begin maxOff = `TPI_MAX_VT15; ssWant = `TPI_SS_VT15; end
      tpi_pkg::TT_VT2:  begin maxOff = `TPI_MAX_VT2;  ssWant = `TPI_SS_VT2;  end
      tpi_pkg::TT_VT3:  begin maxOff = `TPI_MAX_VT3;  ssWant = `TPI_SS_VT3;  end
      tpi_pkg::TT_VT6:  begin maxOff = `TPI_MAX_VT6;  ssWant = `TPI_SS_VT6;  end
      default:          begin maxOff = `TPI_MAX_TU3;  ssWant = `TPI_SS_TU3;  end
    endcase
  end
  logic        eval;
  logic [7:0]  b1;
  logic [9:0]  ptr;
  logic [9:0]  act;
  logic [9:0]  xr;
  tpi_pkg::tpi_state_t st;
  logic ssOk, inRng, enF, disF, majI, majD, spOk, inNorm;
  logic isNorm, isNdf, isAll, isInc, isDec, isNew, isInv, eqNew;
  assign eval   = (phase == 2'h1) && capV2;
  assign b1     = b1Arr[capTrib];
  assign ptr    = {b1[1:0], capByte};
  assign act    = actArr[capTrib];
  assign st     = stArr[capTrib];
  assign inNorm = (st == tpi_pkg::ST_NORM);
  assign xr     = ptr ^ act;
  assign ssOk   = (b1[3:2] == ssWant);
  assign inRng  = (ptr <= maxOff);
  assign enF    = near4(b1[7:4], `TPI_NDF_EN);
  assign disF   = near4(b1[7:4], `TPI_NDF_DIS);
  assign majI   = maj5({xr[9], xr[7], xr[5], xr[3], xr[1]});
  assign majD   = maj5({xr[8], xr[6], xr[4], xr[2], xr[0]});
  assign spOk   = jspOff || (since[capTrib] >= `TPI_JSPACE);
  assign isNorm = disF && ssOk && inNorm && (ptr == act);
  assign isNdf  = enF && ssOk && inRng;
  assign isAll  = (b1 == 8'hff) && (capByte == 8'hff);
  // justification needs an active offset, so only in tracking
  assign isInc  = disF && ssOk && majI && !majD && spOk && inNorm;
  assign isDec  = disF && ssOk && majD && !majI && spOk && inNorm;
  assign isNew  = disF && ssOk && inRng && !isNorm && !isInc && !isDec;
  assign isInv  = !(isNorm || isNdf || isAll || isInc || isDec) || isNew;
  assign eqNew  = isNew && (newCnt[capTrib] == `TPI_EQ_LAST) && (ptr == newOff[capTrib]);
  // next state and offset of the tributary being evaluated
  tpi_pkg::tpi_state_t next_st;
  logic [9:0] next_act;
  always_comb begin
    next_st  = st;
    next_act = act;
    if (eqNew) begin
      next_st  = tpi_pkg::ST_NORM;
      next_act = ptr;
    end else if (isNdf && ndfCnt[capTrib] == `TPI_LOP_LAST && st != tpi_pkg::ST_LOP) begin
      next_st  = tpi_pkg::ST_LOP;
    end else if (isInv && invCnt[capTrib] == `TPI_LOP_LAST && st != tpi_pkg::ST_LOP) begin
      next_st  = tpi_pkg::ST_LOP;
    end else if (isAll && (aisOne || aisCnt[capTrib] == `TPI_AIS_LAST) && st != tpi_pkg::ST_AIS) begin
      next_st  = tpi_pkg::ST_AIS;
    end else if (isNdf && st != tpi_pkg::ST_LOP) begin
      next_st  = tpi_pkg::ST_NORM;
      next_act = ptr;
    end else if (isInc) begin
      next_act = (act == maxOff) ? 10'h000 : act + 10'h001;
    end else if (isDec) begin
      next_act = (act == 10'h000) ? maxOff : act - 10'h001;
    end
  end
  logic changed;
  assign changed = (next_st != st);
  ////////////////////////////////////////////////////////////////////////////
  // state vector ram, one entry touched per slot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NTRIB; i++) begin
        stArr[i]  <= tpi_pkg::ST_LOP;
        actArr[i] <= 10'h000;
        newOff[i] <= 10'h000;
        b1Arr[i]  <= 8'h00;
        invCnt[i] <= 3'h0;
        ndfCnt[i] <= 3'h0;
        aisCnt[i] <= 2'h0;
        newCnt[i] <= 2'h0;
        since[i]  <= 3'h0;
      end
    end else if (phase == 2'h1) begin
      if (capV1) begin
        b1Arr[capTrib] <= capByte;
      end
      if (eval) begin
        stArr[capTrib]  <= next_st;
        actArr[capTrib] <= next_act;
        if (isNew) begin
          newOff[capTrib] <= ptr;
        end
        if (isNdf || isInc || isDec) begin
          since[capTrib] <= 3'h0;
        end else if (since[capTrib] != 3'h7) begin
          since[capTrib] <= since[capTrib] + 3'h1;
        end
        if (changed) begin
          invCnt[capTrib] <= 3'h0;
          ndfCnt[capTrib] <= 3'h0;
          aisCnt[capTrib] <= 2'h0;
          newCnt[capTrib] <= 2'h0;
        end else begin
          invCnt[capTrib] <= isInv ? invCnt[capTrib] + 3'(invCnt[capTrib] != 3'h7) : 3'h0;
          ndfCnt[capTrib] <= isNdf ? ndfCnt[capTrib] + 3'(ndfCnt[capTrib] != 3'h7) : 3'h0;
          aisCnt[capTrib] <= isAll ? aisCnt[capTrib] + 2'(aisCnt[capTrib] != 2'h3) : 2'h0;
          if (!isNew) begin
            newCnt[capTrib] <= 2'h0;
          end else if (newCnt[capTrib] != 2'h0 && ptr == newOff[capTrib]) begin
            newCnt[capTrib] <= newCnt[capTrib] + 2'(newCnt[capTrib] != 2'h3);
          end else begin
            newCnt[capTrib] <= 2'h1;
          end
        end
      end
    end
  end
  // per tributary alarm outputs
  for (genvar g = 0; g < NTRIB; g++) begin : gFlag
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        lopFlag[g] <= 1'b1;
        aisFlag[g] <= 1'b0;
      end else begin
        lopFlag[g] <= (stArr[g] == tpi_pkg::ST_LOP);
        aisFlag[g] <= (stArr[g] == tpi_pkg::ST_AIS);
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // payload fifo bank: write in phase 1, read in phase 2
  logic [8:0]    fifoMem [2**(5+AW)];
  logic [AW-1:0] wFill;
  logic [AW-1:0] rFill;
  logic          doWr;
  assign wFill = wPtr[capTrib] - rPtr[capTrib];
  assign rFill = wPtr[capRdTrib] - rPtr[capRdTrib];
  // a full fifo drops the byte; one slot is kept free so full and empty differ
  assign doWr  = (phase == 2'h1) && capPay && inNorm && (wFill != {AW{1'b1}});
  always_ff @(posedge clk) begin
    if (doWr) begin
      fifoMem[{capTrib, wPtr[capTrib]}] <= {capPos == act, capByte};
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NTRIB; i++) begin
        wPtr[i] <= '0;
        rPtr[i] <= '0;
      end
    end else begin
      if (doWr) begin
        wPtr[capTrib] <= wPtr[capTrib] + 1'b1;
      end
      if (phase == 2'h2 && capRdReq && rFill != '0) begin
        rPtr[capRdTrib] <= rPtr[capRdTrib] + 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdValid <= 1'b0;
      rdData  <= 8'h00;
      rdMark  <= 1'b0;
      rdFill  <= '0;
    end else if (phase == 2'h2) begin
      rdValid <= capRdReq && rFill != '0;
      rdFill  <= rFill;
      if (capRdReq && rFill != '0) begin
        {rdMark, rdData} <= fifoMem[{capRdTrib, rPtr[capRdTrib]}];
      end
    end else begin
      rdValid <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  localparam logic [4:0] CTRL_RST = `TPI_CTRL_RST;
  logic       awHeld;
  logic       wHeld;
  logic [7:0] awA;
  logic [31:0] wD;
  logic [3:0] wS;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      awHeld   <= 1'b0;
      wHeld    <= 1'b0;
      awA      <= 8'h00;
      wD       <= 32'h0000_0000;
      wS       <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= `TPI_RESP_OK;
      // enum field loaded through a cast, not a packed concatenation
      tribType <= tpi_pkg::tpi_trib_t'(CTRL_RST[4:2]);
      aisOne   <= CTRL_RST[`TPI_CTRL_AIS1];
      jspOff   <= CTRL_RST[`TPI_CTRL_JSP];
    end else begin
      if (awvalid && awready) begin
        awA     <= awaddr;
        awHeld  <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wD     <= wdata;
        wS     <= wstrb;
        wHeld  <= 1'b1;
        wready <= 1'b0;
      end
      if (awHeld && wHeld && !bvalid) begin
        bvalid <= 1'b1;
        bresp  <= (awA == `TPI_OFF_CTRL || awA == `TPI_OFF_LOP || awA == `TPI_OFF_AIS) ?
                  `TPI_RESP_OK : `TPI_RESP_ERR;
        if (awA == `TPI_OFF_CTRL && wS[0]) begin
          jspOff   <= wD[`TPI_CTRL_JSP];
          aisOne   <= wD[`TPI_CTRL_AIS1];
          tribType <= tpi_pkg::tpi_trib_t'(wD[`TPI_CTRL_TYPE +: 3]);
        end
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awHeld  <= 1'b0;
        wHeld   <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `TPI_RESP_OK;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= `TPI_RESP_OK;
      case (araddr)
        `TPI_OFF_CTRL: rdata <= 32'({tribType, aisOne, jspOff});
        `TPI_OFF_LOP:  rdata <= 32'(lopFlag);
        `TPI_OFF_AIS:  rdata <= 32'(aisFlag);
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= `TPI_RESP_ERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_slot_three_cycles: assert property (slotFirst |=> !slotFirst ##1 !slotFirst ##1 slotFirst)
    else $error("slot is not three clocks");
  a_eqnew_tracks: assert property (eval && eqNew |=>
    stArr[capTrib] == tpi_pkg::ST_NORM && actArr[capTrib] == $past(ptr))
    else $error("three equal pointers did not set tracking");
  a_bad_to_lost: assert property (eval && isInv && !eqNew && invCnt[capTrib] == 3'h7
    && st == tpi_pkg::ST_NORM |=> stArr[capTrib] == tpi_pkg::ST_LOP ##1 lopFlag[capTrib])
    else $error("eight bad pointers did not enter pointer lost");
  a_ones_no_lost: assert property (eval && isAll && st != tpi_pkg::ST_LOP
    |=> stArr[capTrib] != tpi_pkg::ST_LOP)
    else $error("all-ones pointer caused pointer lost");
  a_ones_to_alarm: assert property (eval && isAll && !aisOne && aisCnt[capTrib] == 2'h2
    && st == tpi_pkg::ST_NORM |=> ##1 aisFlag[capTrib])
    else $error("three all-ones did not raise alarm");
  a_alarm_exit_one: assert property (eval && st == tpi_pkg::ST_AIS && isNdf && ndfCnt[capTrib] != 3'h7
    |=> stArr[capTrib] == tpi_pkg::ST_NORM)
    else $error("flag-enabled pointer did not leave alarm");
  a_inc_steps: assert property (eval && isInc && act != maxOff |=>
    actArr[capTrib] == $past(act) + 10'h001 && stArr[capTrib] == tpi_pkg::ST_NORM)
    else $error("justify up did not step offset");
  a_cnt_cleared: assert property (eval && changed |=>
    invCnt[capTrib] == 3'h0 && aisCnt[capTrib] == 2'h0 && newCnt[capTrib] == 2'h0)
    else $error("counters survived a state change");
  a_inc_spacing: assert property (eval && inNorm && disF && ssOk && majI && !majD && !jspOff
    && !eqNew && since[capTrib] < 3'h3 |=> actArr[capTrib] == $past(act))
    else $error("justification too soon after previous");
  a_empty_no_data: assert property (phase == 2'h2 && capRdReq && rFill == '0 |=> !rdValid)
    else $error("read of empty fifo returned data");
  c_enter_lost: cover property (eval && changed && next_st == tpi_pkg::ST_LOP);
  c_enter_alarm: cover property (eval && changed && next_st == tpi_pkg::ST_AIS);
  c_eq_new: cover property (eval && eqNew);
  c_read_mark: cover property (rdValid && rdMark);
endmodule

// ---- hdl/tpi_regs.svh ----
// register offsets, field positions, reset values and counts of the pointer interpreter
`ifndef TPI_REGS_SVH
`define TPI_REGS_SVH
`define TPI_OFF_CTRL    8'h00
`define TPI_OFF_LOP     8'h04
`define TPI_OFF_AIS     8'h08
`define TPI_CTRL_JSP    0
`define TPI_CTRL_AIS1   1
`define TPI_CTRL_TYPE   2
`define TPI_CTRL_RST    5'h00
`define TPI_MAX_VT15    10'h067
`define TPI_MAX_VT2     10'h08b
`define TPI_MAX_VT3     10'h0d3
`define TPI_MAX_VT6     10'h1ab
`define TPI_MAX_TU3     10'h2fc
`define TPI_SS_VT15     2'h3
`define TPI_SS_VT2      2'h2
`define TPI_SS_VT3      2'h1
`define TPI_SS_VT6      2'h0
`define TPI_SS_TU3      2'h2
`define TPI_NDF_EN      4'h9
`define TPI_NDF_DIS     4'h6
`define TPI_JSPACE      3'h3
`define TPI_AIS_LAST    2'h2
`define TPI_EQ_LAST     2'h2
`define TPI_LOP_LAST    3'h7
`define TPI_RESP_OK     2'h0
`define TPI_RESP_ERR    2'h2
`endif

// ---- test/tpi_framer_model.sv ----
// upstream framer model driving the incoming tributary byte stream
`timescale 1ns/1ps
module tpi_framer_model (
  input  wire logic       clk,
  output logic [4:0]      inTrib,
  output logic            inV1,
  output logic            inV2,
  output logic            inPay,
  output logic [7:0]      inByte,
  output logic [9:0]      inPos
);
  logic [7:0] curByte = 8'h00;
  logic [7:0] idlePat = 8'h5a;
  initial begin
    inTrib = 5'h00;
    {inV1, inV2, inPay} = 3'b000;
    inPos = 10'h000;
  end
  ////////////////////////////////////////////////////////////////
  // released byte lane keeps changing so a stale byte is never mistaken for data
  always @(posedge clk) idlePat <= idlePat + 8'h3b;
  assign inByte = (inV1 | inV2 | inPay) ? curByte : idlePat;
  ////////////////////////////////////////////////////////////////
  // held three clocks: exactly one sampling slot falls inside, whatever the phase
  task automatic put(input logic [4:0] t, input logic [2:0] k, input logic [7:0] b, input logic [9:0] p);
    inTrib <= t;
    {inV1, inV2, inPay} <= k;
    curByte <= b;
    inPos <= p;
    repeat (3) @(posedge clk);
  endtask
  // first pointer byte always ahead of the second of the same tributary
  task automatic ptr(input logic [4:0] t, input logic [3:0] f, input logic [1:0] s, input logic [9:0] o);
    put(t, 3'b100, {f, s, o[9:8]}, 10'h000);
    put(t, 3'b010, o[7:0], 10'h000);
  endtask
  task automatic quiet();
    {inV1, inV2, inPay} <= 3'b000;
    @(posedge clk);
  endtask
endmodule

// ---- test/tpi_pointer_interp_tb_top.sv ----
// self-checking bench of the tributary pointer interpreter
`timescale 1ns/1ps
`include "tpi_regs.svh"
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t %s", $time, m); end end
module tpi_pointer_interp_tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, rdReq = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic [4:0]  rdTrib = 5'h00, inTrib;
  logic        awready, wready, bvalid, arready, rvalid, slotFirst, rdValid, rdMark, inV1, inV2, inPay;
  logic [1:0]  bresp, rresp, r, ss = `TPI_SS_VT15;
  logic [31:0] rdata, d;
  logic [7:0]  rdData, inByte, b;
  logic [9:0]  inPos;
  logic [3:0]  rdFill;
  logic [27:0] lopFlag, aisFlag, expLop = 28'hfffffff, expAis = 28'h0;
  logic [1:0]  ssTab [5] = '{`TPI_SS_VT15, `TPI_SS_VT2, `TPI_SS_VT3, `TPI_SS_VT6, `TPI_SS_TU3};
  logic [9:0]  mxTab [5] = '{`TPI_MAX_VT15, `TPI_MAX_VT2, `TPI_MAX_VT3, `TPI_MAX_VT6, `TPI_MAX_TU3};
  logic [8:0]  payQ[$];
  logic [12:0] gotQ[$];
  int          n_errors = 0, num_checks = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  tpi_pointer_interp #(.NTRIB(28), .FDEPTH(16)) dut_u (.clk, .rst_n, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .slotFirst, .inTrib, .inV1, .inV2, .inPay, .inByte, .inPos, .rdTrib, .rdReq, .rdValid, .rdData,
    .rdMark, .rdFill, .lopFlag, .aisFlag);
  tpi_framer_model fr_u (.clk, .inTrib, .inV1, .inV2, .inPay, .inByte, .inPos);
  always @(posedge clk) if (rdValid === 1'b1) gotQ.push_back({rdFill, rdMark, rdData});
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      $display("BAD %0t timeout", $time);
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    // one idle edge so a ready lowered by the previous call is never raised in the same step
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    {awvalid, wvalid, bready} <= 3'b111;
    while (!(ad && wd)) begin
      @(posedge clk);
      ad = ad | (awready === 1'b1);
      wd = wd | (wready === 1'b1);
      awvalid <= !ad;
      wvalid <= !wd;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // three equal disabled-flag pointers lift pointer loss
  task automatic fix(input logic [4:0] t, input logic [9:0] o);
    repeat (3) fr_u.ptr(t, `TPI_NDF_DIS, ss, o);
  endtask
  task automatic settle();
    fr_u.quiet();
    repeat (6) @(posedge clk);
  endtask
  task automatic allones(input logic [4:0] t, input int n);
    repeat (n) fr_u.ptr(t, 4'hf, 2'h3, 10'h3ff);
  endtask
  // bad runs broken by offset o: pointer loss stays away only if o is the active offset
  task automatic probe(input logic [4:0] t, input logic [9:0] o);
    repeat (2) begin
      fr_u.ptr(t, `TPI_NDF_DIS, ss, o);
      repeat (7) fr_u.ptr(t, 4'h0, ss, o);
    end
    fr_u.ptr(t, `TPI_NDF_DIS, ss, o);
    settle();
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h96e5));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK(lopFlag, expLop, "lop after reset")
    `CHK(aisFlag, expAis, "ais after reset")
    `CHK(slotFirst, 1'b1, "slot marker after reset")
    @(posedge clk);
    `CHK(slotFirst, 1'b0, "slot marker second cycle")
    rd(`TPI_OFF_CTRL, d, r);
    `CHK(d[4:0], `TPI_CTRL_RST, "ctrl reset")
    `CHK(r, `TPI_RESP_OK, "ctrl read resp")
    rd(8'h40, d, r);
    `CHK(r, `TPI_RESP_ERR, "unmapped resp")
    `CHK(d, 32'h0, "unmapped data")
    wr(`TPI_OFF_LOP, 32'h0, r);
    `CHK(r, `TPI_RESP_OK, "lop write resp")
    rd(`TPI_OFF_LOP, d, r);
    `CHK(d[27:0], expLop, "lop reg read only")
    wstrb <= 4'h0;
    wr(`TPI_OFF_CTRL, 32'h3, r);
    wstrb <= 4'hf;
    rd(`TPI_OFF_CTRL, d, r);
    `CHK(d[4:0], `TPI_CTRL_RST, "ctrl masked write")
    $display("test regs done");
    // every flag code, eight in a row from tracking: only disabled codes keep it
    for (int c = 0; c < 16; c++) begin
      fix(5'd2, 10'(20 + c));
      repeat (8) fr_u.ptr(5'd2, 4'(c), ss, 10'(20 + c));
      settle();
      expLop[2] = ((16'h40d4 >> c) & 16'h0001) == 16'h0000;
      `CHK(lopFlag, expLop, "flag decode")
    end
    $display("test flag codes done");
    fix(5'd4, 10'd30);
    repeat (7) fr_u.ptr(5'd4, 4'h0, ss, 10'd30);
    fr_u.ptr(5'd4, `TPI_NDF_DIS, ss, 10'd30);
    repeat (7) fr_u.ptr(5'd4, 4'h0, ss, 10'd30);
    settle();
    expLop[4] = 1'b0;
    `CHK(lopFlag, expLop, "broken run counted")
    fr_u.ptr(5'd4, 4'h0, ss, 10'd30);
    settle();
    expLop[4] = 1'b1;
    `CHK(lopFlag, expLop, "eight bad")
    $display("test bad runs done");
    for (int i = 0; i < 5; i++) begin
      wr(`TPI_OFF_CTRL, 32'(i) << `TPI_CTRL_TYPE, r);
      `CHK(r, `TPI_RESP_OK, "ctrl write resp")
      ss = ssTab[i];
      fix(5'(10 + i), mxTab[i] + 10'd1);
      settle();
      `CHK(lopFlag, expLop, "offset above range")
      fix(5'(10 + i), mxTab[i]);
      settle();
      expLop[10 + i] = 1'b0;
      `CHK(lopFlag, expLop, "offset at range end")
    end
    wr(`TPI_OFF_CTRL, 32'h0, r);
    ss = `TPI_SS_VT15;
    $display("test ranges done");
    fix(5'd7, 10'd40);
    allones(5'd7, 2);
    settle();
    expLop[7] = 1'b0;
    `CHK(aisFlag, expAis, "two all-ones")
    allones(5'd7, 9);
    settle();
    expAis[7] = 1'b1;
    `CHK(aisFlag, expAis, "three all-ones")
    `CHK(lopFlag, expLop, "all-ones no loss")
    fr_u.ptr(5'd7, `TPI_NDF_EN, ss, 10'd41);
    settle();
    expAis[7] = 1'b0;
    `CHK(aisFlag, expAis, "one enabled leaves alarm")
    wr(`TPI_OFF_CTRL, 32'h1 << `TPI_CTRL_AIS1, r);
    allones(5'd7, 1);
    settle();
    expAis[7] = 1'b1;
    `CHK(aisFlag, expAis, "single all-ones option")
    fix(5'd7, 10'd42);
    settle();
    expAis[7] = 1'b0;
    `CHK(aisFlag, expAis, "three equal leave alarm")
    wr(`TPI_OFF_CTRL, 32'h0, r);
    $display("test alarm done");
    // justifications step the offset; one too soon is refused unless spacing is off
    fix(5'd8, 10'd50);
    expLop[8] = 1'b0;
    fr_u.ptr(5'd8, `TPI_NDF_DIS, ss, 10'd50 ^ 10'h2aa);
    fr_u.ptr(5'd8, `TPI_NDF_DIS, ss, 10'd51 ^ 10'h2aa);
    probe(5'd8, 10'd51);
    `CHK(lopFlag, expLop, "justify up, early one refused")
    fr_u.ptr(5'd8, `TPI_NDF_DIS, ss, 10'd51 ^ 10'h155);
    probe(5'd8, 10'd50);
    `CHK(lopFlag, expLop, "justify down")
    wr(`TPI_OFF_CTRL, 32'h1 << `TPI_CTRL_JSP, r);
    fr_u.ptr(5'd8, `TPI_NDF_DIS, ss, 10'd50 ^ 10'h155);
    fr_u.ptr(5'd8, `TPI_NDF_DIS, ss, 10'd49 ^ 10'h2aa);
    probe(5'd8, 10'd50);
    `CHK(lopFlag, expLop, "spacing option")
    wr(`TPI_OFF_CTRL, 32'h0, r);
    $display("test justify done");
    // payload around the overhead byte, then one read more than was written
    fix(5'd3, 10'd10);
    for (int p = 8; p < 14; p++) begin
      b = 8'($urandom);
      fr_u.put(5'd3, 3'b001, b, 10'(p));
      payQ.push_back({p == 10, b});
    end
    fr_u.quiet();
    rdTrib <= 5'd3;
    rdReq <= 1'b1;
    repeat (21) @(posedge clk);
    rdReq <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(32'(gotQ.size()), 32'd6, "read count, empty refused")
    `CHK(gotQ[0][12:9], 4'd6, "fill before read")
    foreach (payQ[i]) `CHK(gotQ[i][8:0], payQ[i], "payload byte and marker")
    $display("test payload done");
    wrap_up();
  end
endmodule
